// ---- logic/otpp_pkg.sv ----
// Package with register map, field layout and constants of the one-time-programmable memory programming interface.
package otpp_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [15:0] OTPP_CTRL_OFS = 16'hedc0; // Control register byte address.
    localparam logic [15:0] OTPP_ADDR_OFS = 16'hedc2; // Address register byte address.
    localparam logic [15:0] OTPP_DATA_OFS = 16'hedc4; // Data register byte address.
    localparam logic [15:0] OTPP_MODE_OFS = 16'hedc6; // Mode and status register byte address.

    // ----------------------------------------
    // Reset values and field positions
    // ----------------------------------------
    localparam logic [15:0] OTPP_CTRL_RST = 16'h0007; // Control reset value, module deselected.
    localparam logic [15:0] OTPP_ADDR_RST = 16'h0000; // Address reset value.
    localparam logic [15:0] OTPP_DATA_RST = 16'h0000; // Data reset value.
    localparam int OTPP_RD_BIT = 0; // Active-low read strobe.
    localparam int OTPP_WR_BIT = 1; // Active-low write strobe.
    localparam int OTPP_CE_BIT = 2; // Active-low module enable.
    localparam int OTPP_RS_BIT = 3; // Register select.
    localparam logic [15:0] OTPP_CTRL_WMASK = 16'hff0f; // Writable control bits.
    localparam logic [15:0] OTPP_ADDR_WMASK = 16'hfffe; // Address line 0 is not kept.
    localparam logic [15:0] OTPP_LOCK_ADDR = 16'h000e; // Protection control location.
    localparam logic [15:0] OTPP_LOCK_WORD = 16'h0000; // Word that arms protection.
    localparam logic [15:0] OTPP_LOCKED_RD = 16'h0000; // Control section read, protection active.
    localparam logic [15:0] OTPP_OPEN_RD = 16'h0001; // Control section read, protection inactive.
    localparam logic [15:0] OTPP_ZERO = 16'h0000; // Blank answer.
    localparam logic [15:0] OTPP_ERASED = 16'hffff; // Unprogrammed cell content.

    // ----------------------------------------
    // Carrier types
    // ----------------------------------------
    // Decoded control register fields.
    typedef struct packed {
        logic [7:0] segment_address;
        logic [3:0] unused;
        logic register_select;
        logic module_enable_n;
        logic write_strobe_n;
        logic read_strobe_n;
    } otpp_ctrl_t;

    // Cycle tracker states, Gray coded so that idle to either strobe and back flips one bit.
    typedef enum logic [1:0] {
        OTPP_IDLE = 2'b00,
        OTPP_WRITE = 2'b01,
        OTPP_READ = 2'b10
    } otpp_state_t;

endpackage

// ---- logic/otpp_top.sv ----
// Programming interface of the one-time-programmable word memory with irreversible read protection.
// ----------------------------------------
// Programming interface top
// ----------------------------------------
// How it works
// - protection refuses every programming cycle to the memory section.
// - protection refuses every verify read of the memory section.
// - protected contents reach only fetches and data reads from own code.
// - zero word to 000e arms protection.
// - verify right after arming shows D0 zero.
// - protection is permanent, nothing clears it.
// - control bits strobes, enable, select, segment.
// - address lines 15..1, data holds word.
module otpp_top
    import otpp_pkg::*;
#(
    parameter int WORDS = 16384, // Memory depth in words.
    parameter int AW = 14 // Word index width.
) (
    input wire logic clk_i, // System clock, 20 MHz.
    input wire logic nrst_i, // Asynchronous active-low reset.
    input wire logic [15:0] addr_i, // Register byte address.
    input wire logic [15:0] wdata_i, // Register write data.
    input wire logic wr_i, // Register write strobe.
    input wire logic rd_i, // Register read strobe.
    input wire logic prog_mode_i, // High while the chip is in programming mode.
    input wire logic vpp_ok_i, // High while programming voltage is present.
    input wire logic fetch_rd_i, // Instruction fetch read of the memory.
    input wire logic own_code_i, // Data read issued by code fetched from this memory.
    input wire logic data_rd_i, // Data read of the memory by the processor.
    input wire logic [AW-1:0] cpu_addr_i, // Processor word address.
    output logic [15:0] rdata_o, // Register read data, one cycle after read strobe.
    output logic [15:0] cpu_rdata_o, // Processor read data, one cycle after request.
    output logic locked_o // Read protection is active.
);

    // Refuse parameter values the address logic cannot serve, already at elaboration.
    if (WORDS > (1 << AW) || AW > 15 || WORDS < 1) begin : g_bad_param
        $error("otpp_top: WORDS and AW do not match");
    end

    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    logic rst_meta_q; // First stage, read only by the second.
    logic rst_n_q; // Released reset used by the design.

    // Releases reset two edges after nrst_i rises.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ----------------------------------------
    // Memory array
    // ----------------------------------------
    logic [15:0] mem_q [WORDS] = '{default: OTPP_ERASED}; // Programmed words, cleared bits only ever drop.
    logic mem_we; // Commit a programming cycle.
    logic [AW-1:0] mem_idx; // Word index of the pending cycle.

    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    otpp_ctrl_t ctrl_q, ctrl_d; // Control register.
    logic [15:0] addr_q, addr_d; // Address register.
    logic [15:0] data_q, data_d; // Data register.
    logic [15:0] rdata_q, rdata_d; // Register read data.
    logic [15:0] cpu_q, cpu_d; // Processor read data.
    logic lock_q = 1'b0; // Read protection fuse, powers up open and is never reset.
    logic lock_d; // Next value of the protection fuse.
    logic refused_q, refused_d; // Last cycle was refused.
    otpp_state_t st_q, st_d; // Cycle tracker.
    otpp_ctrl_t wctrl; // Control view of write data.
    logic ctrl_wr; // Write to the control register.
    logic wr_edge; // Trailing edge of a write strobe.
    logic rd_edge; // Trailing edge of a read strobe.
    logic sel_open; // Module enabled, in programming mode.

    assign wctrl = otpp_ctrl_t'(wdata_i & OTPP_CTRL_WMASK);
    assign ctrl_wr = wr_i && prog_mode_i && addr_i == OTPP_CTRL_OFS;
    assign sel_open = !ctrl_q.module_enable_n && prog_mode_i;
    assign mem_idx = addr_q[AW:1];
    // A strobe ends when software returns it high, even if the same write disables the module.
    assign wr_edge = ctrl_wr && st_q == OTPP_WRITE && wctrl.write_strobe_n;
    assign rd_edge = ctrl_wr && st_q == OTPP_READ && wctrl.read_strobe_n;
    // Programming commits at the trailing edge into the memory section, unless protected.
    assign mem_we = wr_edge && !ctrl_q.register_select && !lock_q && vpp_ok_i;

    // Computes next values of registers, tracker and protection.
    always_comb begin
        ctrl_d = ctrl_q;
        addr_d = addr_q;
        data_d = data_q;
        rdata_d = OTPP_ZERO;
        cpu_d = cpu_q;
        lock_d = lock_q;
        refused_d = refused_q;
        st_d = st_q;
        // Register writes are taken only in programming mode.
        if (wr_i && prog_mode_i) begin
            unique case (addr_i)
                OTPP_CTRL_OFS: ctrl_d = wctrl;
                OTPP_ADDR_OFS: addr_d = wdata_i & OTPP_ADDR_WMASK;
                OTPP_DATA_OFS: data_d = wdata_i;
                default: ;
            endcase
        end
        // Strobe tracking follows the control register.
        unique case (st_q)
            OTPP_IDLE: begin
                if (ctrl_wr && !wctrl.module_enable_n && !wctrl.write_strobe_n) begin
                    st_d = OTPP_WRITE;
                end else if (ctrl_wr && !wctrl.module_enable_n && !wctrl.read_strobe_n) begin
                    st_d = OTPP_READ;
                end
            end
            OTPP_WRITE: begin
                if (ctrl_wr && (wctrl.write_strobe_n || wctrl.module_enable_n)) begin
                    st_d = OTPP_IDLE;
                end
            end
            OTPP_READ: begin
                if (ctrl_wr && (wctrl.read_strobe_n || wctrl.module_enable_n)) begin
                    st_d = OTPP_IDLE;
                end
            end
        endcase
        // Write cycle end: arm protection or flag refusal.
        if (wr_edge && sel_open) begin
            if (ctrl_q.register_select) begin
                if (addr_q == OTPP_LOCK_ADDR && data_q == OTPP_LOCK_WORD && vpp_ok_i) begin
                    lock_d = 1'b1;
                end
                refused_d = 1'b0;
            end else begin
                refused_d = lock_q;
            end
        end
        // Read cycle end: load data register from the addressed location.
        if (rd_edge && sel_open) begin
            if (ctrl_q.register_select) begin
                data_d = lock_q ? OTPP_LOCKED_RD : OTPP_OPEN_RD;
                refused_d = 1'b0;
            end else if (lock_q) begin
                data_d = OTPP_ZERO;
                refused_d = 1'b1;
            end else begin
                data_d = mem_q[mem_idx];
                refused_d = 1'b0;
            end
        end
        // Register reads answer in the next cycle; unmapped reads give zero.
        if (rd_i && prog_mode_i) begin
            unique case (addr_i)
                OTPP_CTRL_OFS: rdata_d = ctrl_q;
                OTPP_ADDR_OFS: rdata_d = addr_q;
                OTPP_DATA_OFS: rdata_d = data_q;
                OTPP_MODE_OFS: rdata_d = {14'h0000, refused_q, lock_q};
                default: rdata_d = OTPP_ZERO;
            endcase
        end
        // Normal reads: fetches always, data reads only from own code when protected.
        if (fetch_rd_i || (data_rd_i && (!lock_q || own_code_i))) begin
            cpu_d = mem_q[cpu_addr_i];
        end else if (data_rd_i) begin
            cpu_d = OTPP_ZERO;
        end
    end

    // Registers the control and status state.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= otpp_ctrl_t'(OTPP_CTRL_RST);
            addr_q <= OTPP_ADDR_RST;
            data_q <= OTPP_DATA_RST;
            rdata_q <= OTPP_ZERO;
            cpu_q <= OTPP_ZERO;
            refused_q <= 1'b0;
            st_q <= OTPP_IDLE;
        end else begin
            ctrl_q <= ctrl_d;
            addr_q <= addr_d;
            data_q <= data_d;
            rdata_q <= rdata_d;
            cpu_q <= cpu_d;
            refused_q <= refused_d;
            st_q <= st_d;
        end
    end

    // Protection models a nonvolatile fuse, so reset does not clear it.
    // Its power-up value comes from the declaration, so only this process writes it.
    always_ff @(posedge clk_i) begin
        lock_q <= lock_d;
    end

    // Programming can only clear bits, like a real one-time cell.
    genvar gi;
    generate
        for (gi = 0; gi < WORDS; gi++) begin : g_word
            // Each word has its own write port; the erased content comes from the declaration.
            always_ff @(posedge clk_i) begin
                if (mem_we && mem_idx == AW'(gi)) begin
                    mem_q[gi] <= mem_q[gi] & data_q;
                end
            end
        end
    endgenerate

    assign rdata_o = rdata_q;
    assign cpu_rdata_o = cpu_q;
    assign locked_o = lock_q;

endmodule

// ---- testbench/otpp_vpp_model.sv ----
// Behavioural model of the external programming voltage supply.
module otpp_vpp_model #(
    parameter int SETTLE = 200 // Settle time in clock cycles.
) (
    input wire logic clk_i, // System clock.
    input wire logic en_i, // Switches the voltage on.
    output logic ok_o // Voltage is present and settled.
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0; // Cycles since the voltage was switched on.
    // Counts up while on; the supply is good only after a full settle time.
    always @(posedge clk_i) begin
        cnt <= en_i ? ((cnt < SETTLE) ? cnt + 1 : cnt) : 0;
    end
    assign ok_o = en_i && cnt == SETTLE;
endmodule

// ---- testbench/otpp_top_asserts.sv ----
// Concurrent checks on the ports of the programming interface top.
module otpp_top_asserts
    import otpp_pkg::*;
#(
    parameter int AW = 14 // Word index width.
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic prog_mode_i,
    input wire logic vpp_ok_i,
    input wire logic fetch_rd_i,
    input wire logic own_code_i,
    input wire logic data_rd_i,
    input wire logic [AW-1:0] cpu_addr_i,
    input wire logic [15:0] rdata_o,
    input wire logic [15:0] cpu_rdata_o,
    input wire logic locked_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Status read, and the trailing-edge write of an arming cycle.
    wire logic st_rd = rd_i && prog_mode_i && addr_i == OTPP_MODE_OFS;
    wire logic arm_w = wr_i && prog_mode_i && vpp_ok_i && addr_i == OTPP_CTRL_OFS && wdata_i[3:0] == 4'hb;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    AST_LOCK_STICKY: assert property (locked_o |=> locked_o) else $error("protection dropped");
    AST_LOCK_CAUSE: assert property ($rose(locked_o) |-> $past(arm_w) || $past(arm_w, 2))
        else $error("protection armed without arming write");
    AST_PROT_DATA: assert property (locked_o && data_rd_i && !own_code_i |=> cpu_rdata_o == OTPP_ZERO)
        else $error("protected word leaked");
    AST_CPU_HOLD: assert property (!fetch_rd_i && !data_rd_i |=> $stable(cpu_rdata_o))
        else $error("processor data changed without read");
    AST_RD_IDLE: assert property (!rd_i |=> rdata_o == OTPP_ZERO) else $error("read data outside slot");
    AST_RD_NOMODE: assert property (rd_i && !prog_mode_i |=> rdata_o == OTPP_ZERO)
        else $error("register read outside programming mode");
    AST_ST_LOCKED: assert property (st_rd && locked_o |=> rdata_o[0]) else $error("status misses lock");
    AST_ST_OPEN: assert property (st_rd && !locked_o |=> !rdata_o[0]) else $error("status shows lock");
    AST_UNMAPPED: assert property (rd_i && prog_mode_i && addr_i == 16'hedc8 |=> rdata_o == OTPP_ZERO)
        else $error("unmapped read not zero");
    COV_ARM: cover property ($rose(locked_o));
    COV_ST_LOCKED: cover property (st_rd && locked_o);
    COV_PROT_DATA: cover property (locked_o && data_rd_i && !own_code_i);
endmodule
bind otpp_top otpp_top_asserts #(.AW(AW)) u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .prog_mode_i(prog_mode_i), .vpp_ok_i(vpp_ok_i),
    .fetch_rd_i(fetch_rd_i), .own_code_i(own_code_i), .data_rd_i(data_rd_i), .cpu_addr_i(cpu_addr_i),
    .rdata_o(rdata_o), .cpu_rdata_o(cpu_rdata_o), .locked_o(locked_o));

// ---- testbench/otpp_top_test.sv ----
// Self-checking testbench of the programming interface.
module otpp_top_test
    import otpp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SETTLE = 200; // 10 us at 50 ns.
    localparam int HOLD = 2000; // 100 us at 50 ns.
    logic clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, prog_mode_i = 1'b1, vpp_en = 1'b0;
    logic fetch_rd_i = 1'b0, own_code_i = 1'b0, data_rd_i = 1'b0, vpp_ok_i, locked_o;
    logic [15:0] addr_i = 16'h0000, wdata_i = 16'h0000, rdata_o, cpu_rdata_o;
    int error_cnt = 0, checks = 0, cycles = 0;
    otpp_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .prog_mode_i(prog_mode_i), .vpp_ok_i(vpp_ok_i), .fetch_rd_i(fetch_rd_i), .own_code_i(own_code_i),
        .data_rd_i(data_rd_i), .cpu_addr_i(14'd8), .rdata_o(rdata_o), .cpu_rdata_o(cpu_rdata_o), .locked_o(locked_o));
    otpp_vpp_model #(.SETTLE(SETTLE)) u_vpp (.clk_i(clk_i), .en_i(vpp_en), .ok_o(vpp_ok_i));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic tally_and_finish();
        if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // A hung run counts as a mismatch.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 10000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rst();
        nrst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask
    task automatic wrr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rdr(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, e);
    endtask
    // Strobe phase, hold, then the idle pattern as trailing edge.
    task automatic cyc(input logic [15:0] c, input int hold);
        wrr(OTPP_CTRL_OFS, c);
        repeat (hold) @(posedge clk_i);
        wrr(OTPP_CTRL_OFS, c | 16'h0003);
    endtask
    task automatic vpp(input logic on);
        @(posedge clk_i);
        vpp_en <= on;
        repeat (SETTLE + 1) @(posedge clk_i);
    endtask
    task automatic cpu(input logic dr, input logic own, input logic [15:0] e);
        @(posedge clk_i);
        fetch_rd_i <= !dr;
        data_rd_i <= dr;
        own_code_i <= own;
        @(posedge clk_i);
        fetch_rd_i <= 1'b0;
        data_rd_i <= 1'b0;
        #1;
        chk(cpu_rdata_o, e);
    endtask
    initial begin
        rst();
        rdr(OTPP_CTRL_OFS, OTPP_CTRL_RST);
        rdr(OTPP_DATA_OFS, OTPP_DATA_RST);
        rdr(OTPP_MODE_OFS, 16'h0000);
        wrr(OTPP_CTRL_OFS, 16'hffff);
        rdr(OTPP_CTRL_OFS, 16'hff0f);
        wrr(OTPP_CTRL_OFS, 16'h0003);
        wrr(OTPP_ADDR_OFS, 16'h0011);
        rdr(OTPP_ADDR_OFS, 16'h0010);
        wrr(OTPP_DATA_OFS, 16'h5a3c);
        vpp(1'b1);
        cyc(16'h0001, HOLD);
        vpp(1'b0);
        cyc(16'h0002, 0);
        rdr(OTPP_DATA_OFS, 16'h5a3c);
        cpu(1'b0, 1'b0, 16'h5a3c);
        cyc(16'h000a, 0);
        rdr(OTPP_DATA_OFS, OTPP_OPEN_RD);
        vpp(1'b1);
        wrr(OTPP_ADDR_OFS, OTPP_LOCK_ADDR);
        wrr(OTPP_DATA_OFS, OTPP_LOCK_WORD);
        cyc(16'h0009, HOLD);
        cyc(16'h000a, 0);
        rdr(OTPP_DATA_OFS, OTPP_LOCKED_RD);
        chk({15'h0000, locked_o}, 16'h0001);
        wrr(OTPP_ADDR_OFS, 16'h0010);
        wrr(OTPP_DATA_OFS, 16'h0000);
        cyc(16'h0001, HOLD);
        cyc(16'h0002, 0);
        rdr(OTPP_DATA_OFS, 16'h0000);
        rdr(OTPP_MODE_OFS, 16'h0003);
        cpu(1'b0, 1'b0, 16'h5a3c);
        cpu(1'b1, 1'b0, 16'h0000);
        cpu(1'b1, 1'b1, 16'h5a3c);
        vpp(1'b0);
        wrr(OTPP_CTRL_OFS, 16'h0007);
        rdr(16'hedc8, 16'h0000);
        rst();
        chk({15'h0000, locked_o}, 16'h0001);
        // Outside programming mode the bus reads zero and drops writes.
        prog_mode_i <= 1'b0;
        rdr(OTPP_CTRL_OFS, 16'h0000);
        wrr(OTPP_DATA_OFS, 16'hffff);
        prog_mode_i <= 1'b1;
        rdr(OTPP_DATA_OFS, OTPP_DATA_RST);
        tally_and_finish();
    end
endmodule
